/* rtl/sdw_write_port.sv */
`timescale 1ns/100ps
// How it works
// - a frame begins on a high-to-low transition of the frame select, or when it is low at reset release.
// - while frame select is low each serial clock falling edge up to the 24th shifts the data bit into a 24-bit register.
// - the 24th falling edge captures the last bit and at once loads the code and the mode.
// - frames go most significant bit first, bits 23-18 ignored, bits 17:16 mode, bits 15:0 code.
// - the code is two's complement and zero means the middle of the reference range.
// - mode 00 is normal, 01 is about 1 kOhm to ground, 10 about 100 kOhm, 11 high impedance.
// - any power-down mode shuts the analog part and switches the output pin to its termination.
// - a power-down frame still loads its bits 15:0 as the held code, and normal mode keeps the last code loaded.
// - after power-up the output sits at midscale until the first complete valid frame executes.
// - frame select rising before the 24th edge aborts the frame and clears the shift register.
// - an aborted frame changes neither the held code nor the mode.
module sdw_write_port
    import sdw_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SYNC_N,
    input wire logic SCLK,
    input wire logic DIN,
    output logic [15:0] SAMPLE_CODE,
    output logic [1:0] PWRDN_MODE,
    output logic ANALOG_EN,
    output logic OUT_TERM_1K,
    output logic OUT_TERM_100K,
    output logic OUT_TERM_HIZ,
    output logic UPDATE_STB
);

    typedef enum logic [1:0] {
        SDW_ST_IDLE,
        SDW_ST_SHIFT,
        SDW_ST_DONE
    } sdw_state_t;

    logic [2:0] pins_s;
    sdw_link_ev_t ev;
    sdw_state_t state_r;
    sdw_state_t state_nxt;
    logic [SDW_FRAME_BITS-1:0] shift_r;
    logic [SDW_CNT_BITS-1:0] cnt_r;
    logic [SDW_FRAME_BITS-1:0] frame_full;
    logic exec;
    sdw_out_t held_r;

    // pins arrive from the host's domain, so two stages before any use
    sdw_sync2 #(
        .WIDTH(3),
        .INIT(3'h4)
    ) u_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .async_in({SYNC_N, SCLK, DIN}),
        .sync_out(pins_s)
    );

    sdw_edge_det u_edge (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .sync_n_s(pins_s[2]),
        .sclk_s(pins_s[1]),
        .din_s(pins_s[0]),
        .ev(ev)
    );

    // msb first: last bit enters at position 0
    assign frame_full = {shift_r[SDW_FRAME_BITS-2:0], ev.data};
    assign exec = (state_r == SDW_ST_SHIFT) && ev.clk_fall && !ev.frame_abort && (cnt_r == SDW_LAST_BIT);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SDW_ST_IDLE: begin
                if (ev.frame_start) begin
                    state_nxt = SDW_ST_SHIFT;
                end
            end
            SDW_ST_SHIFT: begin
                if (ev.frame_abort) begin
                    state_nxt = SDW_ST_IDLE;
                end else if (exec) begin
                    state_nxt = SDW_ST_DONE;
                end
            end
            SDW_ST_DONE: begin
                if (ev.frame_abort) begin
                    state_nxt = SDW_ST_IDLE;
                end
            end
            default: begin
                state_nxt = SDW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r <= SDW_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // a sync low at reset release starts a frame: sync stages and delay reset high, so it reads as a falling edge
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            shift_r <= SDW_SHIFT_RESET;
            cnt_r <= '0;
        end else if (ev.frame_start || ev.frame_abort) begin
            shift_r <= SDW_SHIFT_RESET;
            cnt_r <= '0;
        end else if (state_r == SDW_ST_SHIFT && ev.clk_fall) begin
            shift_r <= frame_full;
            cnt_r <= cnt_r + 5'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            held_r.mode <= SDW_MODE_NORMAL;
            held_r.code <= SDW_CODE_RESET;
        end else if (exec) begin
            held_r.mode <= sdw_mode_t'(frame_full[SDW_MODE_HI_POS:SDW_MODE_LO_POS]);
            held_r.code <= frame_full[SDW_CODE_MSB_POS:SDW_CODE_LSB_POS];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            SAMPLE_CODE <= SDW_CODE_RESET;
            PWRDN_MODE <= SDW_MODE_NORMAL;
            UPDATE_STB <= 1'b0;
        end else begin
            SAMPLE_CODE <= held_r.code;
            PWRDN_MODE <= held_r.mode;
            UPDATE_STB <= exec;
        end
    end

    // analog off and termination in power-down
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ANALOG_EN <= 1'b1;
            OUT_TERM_1K <= 1'b0;
            OUT_TERM_100K <= 1'b0;
            OUT_TERM_HIZ <= 1'b0;
        end else begin
            ANALOG_EN <= (held_r.mode == SDW_MODE_NORMAL);
            OUT_TERM_1K <= (held_r.mode == SDW_MODE_PD_1K);
            OUT_TERM_100K <= (held_r.mode == SDW_MODE_PD_100K);
            OUT_TERM_HIZ <= (held_r.mode == SDW_MODE_PD_HIZ);
        end
    end

endmodule

/* rtl/sdw_pkg.sv */
package sdw_pkg;

    localparam int SDW_FRAME_BITS = 24;
    localparam int SDW_CODE_BITS = 16;
    localparam int SDW_CNT_BITS = 5;

    // frame field positions
    localparam int SDW_MODE_HI_POS = 17;
    localparam int SDW_MODE_LO_POS = 16;
    localparam int SDW_CODE_MSB_POS = 15;
    localparam int SDW_CODE_LSB_POS = 0;

    localparam logic [4:0] SDW_LAST_BIT = 5'h17;

    // power-down mode field encodings
    typedef enum logic [1:0] {
        SDW_MODE_NORMAL = 2'h0,
        SDW_MODE_PD_1K = 2'h1,
        SDW_MODE_PD_100K = 2'h2,
        SDW_MODE_PD_HIZ = 2'h3
    } sdw_mode_t;

    localparam logic [15:0] SDW_CODE_RESET = 16'h0000;
    localparam logic [23:0] SDW_SHIFT_RESET = 24'h000000;

    // link timing, host side limits
    localparam real SDW_SYS_PERIOD_NS = 4.0;
    localparam real SDW_SYNC_HIGH_MIN_NS = 33.0;
    localparam int SDW_SYNC_HIGH_MIN_CYC = (SDW_SYNC_HIGH_MIN_NS / SDW_SYS_PERIOD_NS) > 8.0 ? 9 : 1;
    localparam real SDW_SCLK_MAX_MHZ = 30.0;

    // state held for the analog side
    typedef struct packed {
        sdw_mode_t mode;
        logic [15:0] code;
    } sdw_out_t;

    // one decoded link event in the system clock domain
    typedef struct packed {
        logic frame_start;
        logic frame_abort;
        logic clk_fall;
        logic data;
    } sdw_link_ev_t;

endpackage

/* rtl/sdw_sync2.sv */
`timescale 1ns/100ps
module sdw_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* rtl/sdw_edge_det.sv */
`timescale 1ns/100ps
module sdw_edge_det
    import sdw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_n_s,
    input wire logic sclk_s,
    input wire logic din_s,
    output sdw_link_ev_t ev
);

    logic sync_n_d_r;
    logic sclk_d_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_n_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            sync_n_d_r <= sync_n_s;
            sclk_d_r <= sclk_s;
        end
    end

    always_comb begin
        ev.frame_start = sync_n_d_r & ~sync_n_s;
        ev.frame_abort = ~sync_n_d_r & sync_n_s;
        ev.clk_fall = sclk_d_r & ~sclk_s & ~sync_n_s;
        ev.data = din_s;
    end

endmodule

/* tb/sdw_props.sv */
`timescale 1ns/100ps
module sdw_props
    import sdw_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SYNC_N,
    input wire logic [15:0] SAMPLE_CODE,
    input wire logic [1:0] PWRDN_MODE,
    input wire logic ANALOG_EN,
    input wire logic OUT_TERM_1K,
    input wire logic OUT_TERM_100K,
    input wire logic OUT_TERM_HIZ,
    input wire logic UPDATE_STB
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_sel_idle;
        SYNC_N [*8];
    endsequence
    sequence s_exec;
        UPDATE_STB ##1 1'b1;
    endsequence
    AST_STB_PULSE: assert property (UPDATE_STB |=> !UPDATE_STB)
        else $error("update strobe too long");
    // the strobe leads the held outputs by one cycle, so look one cycle back
    AST_CODE_HOLD: assert property (!$past(UPDATE_STB) |-> $stable(SAMPLE_CODE))
        else $error("code moved without a frame");
    AST_MODE_HOLD: assert property (!$past(UPDATE_STB) |-> $stable(PWRDN_MODE))
        else $error("mode moved without a frame");
    AST_NO_LATE_STB: assert property (s_sel_idle |=> !UPDATE_STB)
        else $error("strobe while deselected");
    AST_EN_MODE: assert property (s_exec |-> ANALOG_EN == (PWRDN_MODE == SDW_MODE_NORMAL))
        else $error("analog enable wrong");
    AST_TERM_SEL: assert property (s_exec |-> {OUT_TERM_1K, OUT_TERM_100K, OUT_TERM_HIZ} ==
        {PWRDN_MODE == SDW_MODE_PD_1K, PWRDN_MODE == SDW_MODE_PD_100K, PWRDN_MODE == SDW_MODE_PD_HIZ})
        else $error("termination select wrong");
    AST_EN_CAUSE: assert property ($changed(ANALOG_EN) |-> $past(UPDATE_STB))
        else $error("enable moved without a frame");
    AST_RST_VAL: assert property ($rose(RST_N) |-> SAMPLE_CODE == SDW_CODE_RESET && ANALOG_EN)
        else $error("reset values wrong");
endmodule
bind sdw_write_port sdw_props u_props (.SYS_CLK, .RST_N, .SYNC_N, .SAMPLE_CODE, .PWRDN_MODE, .ANALOG_EN,
    .OUT_TERM_1K, .OUT_TERM_100K, .OUT_TERM_HIZ, .UPDATE_STB);

/* tb/sdw_host.sv */
`timescale 1ns/100ps
module sdw_host
    import sdw_pkg::*;
(
    input wire logic clk,
    output logic sync_n,
    output logic sclk,
    output logic din
);
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    // half of a 32 ns link period
    task automatic half;
        repeat (4) @(negedge clk);
    endtask
    task automatic send(input logic [23:0] f, input int n);
        logic [23:0] s;
        s = f;
        sync_n <= 1'b1;
        repeat (SDW_SYNC_HIGH_MIN_CYC) @(negedge clk);
        sync_n <= 1'b0;
        half();
        // msb first, one bit per fall
        for (int i = 0; i < n; i++) begin
            din <= s[23];
            s = {s[22:0], ~s[23]};
            half();
            sclk <= 1'b0;
            half();
            sclk <= 1'b1;
        end
        din <= ~din;
        if (n < SDW_FRAME_BITS) sync_n <= 1'b1;
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
    import sdw_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sync_n, sclk, din, en, t1, t100, thz, stb;
    logic [15:0] code;
    logic [1:0] mode;
    logic [15:0] ecode = SDW_CODE_RESET;
    logic [1:0] emode = SDW_MODE_NORMAL;
    int fails = 0;
    int checks_done = 0;
    int nstb = 0;
    always #2 clk = ~clk;
    // count on the falling edge, where the strobe has settled
    always @(negedge clk) if (stb === 1'b1) nstb++;
    sdw_host host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
    sdw_write_port dut (.SYS_CLK(clk), .RST_N(rst_n), .SYNC_N(sync_n), .SCLK(sclk), .DIN(din),
        .SAMPLE_CODE(code), .PWRDN_MODE(mode), .ANALOG_EN(en), .OUT_TERM_1K(t1),
        .OUT_TERM_100K(t100), .OUT_TERM_HIZ(thz), .UPDATE_STB(stb));
    task chk(input string n, input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task outs;
        chk("code", code, ecode);
        chk("mode", 16'(mode), 16'(emode));
        chk("en", 16'(en), 16'(emode == 2'h0));
        chk("term", 16'({t1, t100, thz}), 16'({emode == 2'h1, emode == 2'h2, emode == 2'h3}));
    endtask
    task frame(input logic [23:0] f, input int n, input int e);
        int s;
        s = nstb;
        host.send(f, n);
        repeat (12) @(negedge clk);
        chk("strobes", 16'(nstb - s), 16'(e));
        outs();
    endtask
    task t_reset;
        outs();
        $display("test reset done");
    endtask
    task t_load;
        ecode = 16'h8000;
        frame(24'hfc8000, 24, 1);
        ecode = 16'h7fff;
        frame(24'hc07fff, 26, 1);
        $display("test load done");
    endtask
    task t_modes;
        for (int m = 1; m < 4; m++) begin
            emode = 2'(m);
            frame({6'h00, emode, ecode}, 24, 1);
        end
        emode = SDW_MODE_NORMAL;
        frame({8'h00, ecode}, 24, 1);
        $display("test modes done");
    endtask
    task t_abort;
        frame(24'h035555, 23, 0);
        ecode = 16'h0f0f;
        frame(24'h000f0f, 24, 1);
        $display("test abort done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_load();
        t_modes();
        t_abort();
        results();
    end
    initial begin
        repeat (10000) @(negedge clk);
        fails++;
        results();
    end
endmodule
